// ==== far_radio_model.sv ====
// Behavioural model of the receiving radio that acknowledges packets.
`timescale 1ns/10ps
module far_radio_model (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       new_packet,
    input  wire logic       tx_start,
    input  wire logic [7:0] ack_on,
    output logic            ack_seen
);
    logic [7:0] n_sent_r;
    logic [3:0] wait_r;

    initial begin
        ack_seen = 1'b0;
        n_sent_r = 8'h00;
        wait_r   = 4'h0;
    end

    // Sends are counted per packet; zero ack_on models a peer whose own
    // retries are off, so it never answers and a sender with retries on must give up.
    // Sampling on the rising edge sees the bench's and the design's
    // values settled, so no same-step race with the falling-edge stimulus.
    // peer acknowledges packet
    always @(posedge clock) begin
        ack_seen <= 1'b0;
        if (rst || new_packet) begin
            n_sent_r <= 8'h00;
            wait_r   <= 4'h0;
        end else if (tx_start) begin
            n_sent_r <= n_sent_r + 8'h01;
            if (ack_on != 8'h00 && n_sent_r + 8'h01 == ack_on) begin
                wait_r <= 4'h3; // Answer a few cycles after the send.
            end
        end else if (wait_r != 4'h0) begin
            wait_r <= wait_r - 4'h1;
            if (wait_r == 4'h1) begin
                ack_seen <= 1'b1;
            end
        end
    end
endmodule : far_radio_model

// ==== radio_link_param_pkg.sv ====
// Shared constants and types for the radio link parameter store.
package radio_link_param_pkg;

    // Binary command codes of the parameters held here.
    localparam logic [7:0] CODE_RETRY_LIMIT  = 8'h18;
    localparam logic [7:0] CODE_SIGNAL_LEVEL = 8'h1C;
    localparam logic [7:0] CODE_LINE_TWO     = 8'h16;
    localparam logic [7:0] CODE_STOP_BITS    = 8'h36;
    localparam logic [7:0] CODE_SERIAL_HIGH  = 8'h25;

    // Values after reset.
    localparam logic [7:0]  RETRY_LIMIT_RST  = 8'h00;
    localparam logic [7:0]  LINE_TWO_RST     = 8'h00;
    localparam logic [7:0]  STOP_BITS_RST    = 8'h00;
    localparam logic [7:0]  SIGNAL_LEVEL_RST = 8'h06;
    localparam logic [15:0] SERIAL_HIGH_RST  = 16'h0000;

    // Legal ranges.
    localparam logic [7:0] SIGNAL_LEVEL_MIN = 8'h06;
    localparam logic [7:0] SIGNAL_LEVEL_MAX = 8'h36;
    localparam logic [7:0] LINE_TWO_MAX     = 8'h02;
    localparam logic [7:0] STOP_BITS_MAX    = 8'h01;

    // Second input line modes.
    localparam logic [7:0] LINE_TWO_UNUSED   = 8'h00;
    localparam logic [7:0] LINE_TWO_BIN_PROG = 8'h01;
    localparam logic [7:0] LINE_TWO_RTS_FLOW = 8'h02;

    // Delay slot length in microseconds and its length in clock cycles.
    localparam int SLOT_TIME_US  = 38000;
    localparam int CLOCK_MHZ     = 20;
    localparam int SLOT_CYCLES   = SLOT_TIME_US * CLOCK_MHZ;

    // Seed of the backoff pseudo-random generator.
    localparam logic [15:0] LFSR_SEED = 16'hACE1;

    // Retransmission sequencer states.
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_SEND    = 4'b0010,
        ST_WAIT    = 4'b0100,
        ST_BACKOFF = 4'b1000
    } retry_state_t;

endpackage : radio_link_param_pkg

// ==== radio_link_param_store.sv ====
// Parameter store and acknowledged-retransmission sequencer of the radio.
`timescale 1ns/10ps
// Behaviour
// - Eight-bit retry limit; zero turns off acknowledgements and retries.
// - With retries on, a sent packet waits for an acknowledgement.
// - No acknowledgement within the delay-slot window resends the packet.
// - Resending stops on acknowledgement or after retry-limit sends.
// - Before a resend wait random zero to count-minus-one 38 ms slots.
// - Retry limit answers on code 0x18 with one byte.
// - Read-only signal level of last packet, 0x06 to 0x36.
// - Signal level answers on code 0x1C with one byte.
// - Line two mode 0 unused, 1 programming, 2 RTS; resets to 0.
// - Stop bits 0 means one, 1 means two; resets 0; code 0x36.
// - Upper serial number word, read-only, two bytes, code 0x25.
module radio_link_param_store
    import radio_link_param_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        cmd_valid,
    input  wire logic        cmd_write,
    input  wire logic [7:0]  cmd_code,
    input  wire logic [15:0] cmd_wdata,
    output logic             cmd_done,
    output logic             cmd_reject,
    output logic [15:0]      cmd_rdata,
    input  wire logic        tx_request,
    input  wire logic        ack_seen,
    input  wire logic [7:0]  delay_slot_count,
    output logic             tx_start,
    output logic             tx_done,
    output logic             tx_failed,
    input  wire logic        rx_level_valid,
    input  wire logic [7:0]  rx_level,
    input  wire logic [15:0] serial_high_strap,
    output logic             retry_enable,
    output logic [7:0]       input_line_two_config,
    output logic             two_stop_bits
);
    logic [7:0]   retry_limit_r;
    logic [7:0]   last_packet_signal_level_r;
    logic [7:0]   input_line_two_config_r;
    logic [7:0]   stop_bit_select_r;
    logic [15:0]  serial_number_upper_word_r;
    logic         strap_pending_r;
    logic         wr_ok;
    logic         known;
    logic [15:0]  rd_nxt;
    retry_state_t state_r;
    logic [7:0]   limit_r;
    logic [7:0]   sends_r;
    logic [15:0]  lfsr_r;
    logic         timer_start;
    logic [7:0]   timer_slots;
    logic         timer_busy;
    logic         timer_expired;
    logic [7:0]   backoff_slots;
    logic [7:0]   ack_window;

    // Read mux and write legality for one command.
    always_comb begin
        known  = 1'b1;
        wr_ok  = 1'b0;
        rd_nxt = 16'h0000;
        unique case (cmd_code)
            CODE_RETRY_LIMIT: begin
                rd_nxt = {8'h00, retry_limit_r};
                wr_ok  = cmd_wdata[15:8] == 8'h00;
            end
            CODE_SIGNAL_LEVEL: begin
                rd_nxt = {8'h00, last_packet_signal_level_r};
            end
            CODE_LINE_TWO: begin
                rd_nxt = {8'h00, input_line_two_config_r};
                wr_ok  = cmd_wdata <= {8'h00, LINE_TWO_MAX};
            end
            CODE_STOP_BITS: begin
                rd_nxt = {8'h00, stop_bit_select_r};
                wr_ok  = cmd_wdata <= {8'h00, STOP_BITS_MAX};
            end
            CODE_SERIAL_HIGH: begin
                rd_nxt = serial_number_upper_word_r;
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end

    // Command answer, one cycle after the request.
    // refuse bad writes
    always_ff @(posedge clock) begin
        if (rst) begin
            cmd_done   <= 1'b0;
            cmd_reject <= 1'b0;
            cmd_rdata  <= 16'h0000;
        end else if (ce) begin
            cmd_done   <= cmd_valid && known && (!cmd_write || wr_ok);
            cmd_reject <= cmd_valid && (!known || (cmd_write && !wr_ok));
            if (cmd_valid && !cmd_write && known) begin
                cmd_rdata <= rd_nxt;
            end
        end
    end

    // Writable parameters change only on an accepted write.
    // retry limit storage
    always_ff @(posedge clock) begin
        if (rst) begin
            retry_limit_r           <= RETRY_LIMIT_RST;
            input_line_two_config_r <= LINE_TWO_RST;
            stop_bit_select_r       <= STOP_BITS_RST;
        end else if (ce && cmd_valid && cmd_write && wr_ok) begin
            if (cmd_code == CODE_RETRY_LIMIT) begin
                retry_limit_r <= cmd_wdata[7:0];
            end
            if (cmd_code == CODE_LINE_TWO) begin
                input_line_two_config_r <= cmd_wdata[7:0];
            end
            if (cmd_code == CODE_STOP_BITS) begin
                stop_bit_select_r <= cmd_wdata[7:0];
            end
        end
    end

    // Received level is clamped, so a noisy report never leaves the range.
    // clamp signal level
    always_ff @(posedge clock) begin
        if (rst) begin
            last_packet_signal_level_r <= SIGNAL_LEVEL_RST;
        end else if (ce && rx_level_valid) begin
            if (rx_level < SIGNAL_LEVEL_MIN) begin
                last_packet_signal_level_r <= SIGNAL_LEVEL_MIN;
            end else if (rx_level > SIGNAL_LEVEL_MAX) begin
                last_packet_signal_level_r <= SIGNAL_LEVEL_MAX;
            end else begin
                last_packet_signal_level_r <= rx_level;
            end
        end
    end

    // The strap is caught on the first enabled edge after reset release.
    // capture serial word
    always_ff @(posedge clock) begin
        if (rst) begin
            strap_pending_r            <= 1'b1;
            serial_number_upper_word_r <= SERIAL_HIGH_RST;
        end else if (ce && strap_pending_r) begin
            strap_pending_r            <= 1'b0;
            serial_number_upper_word_r <= serial_high_strap;
        end
    end

    // line two and stop bit outputs
    assign input_line_two_config = input_line_two_config_r;
    assign two_stop_bits         = stop_bit_select_r[0];
    assign retry_enable          = retry_limit_r != 8'h00;

    // Free-running generator; its low byte picks the backoff length.
    always_ff @(posedge clock) begin
        if (rst) begin
            lfsr_r <= LFSR_SEED;
        end else if (ce) begin
            lfsr_r <= {lfsr_r[14:0],
                       lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        end
    end

    assign backoff_slots = (delay_slot_count == 8'h00) ? 8'h00 :
                           lfsr_r[7:0] % delay_slot_count;
    assign ack_window    = (delay_slot_count == 8'h00) ? 8'h01 :
                           delay_slot_count;

    // The timer is armed on entry to the wait and the backoff states.
    always_comb begin
        timer_start = 1'b0;
        timer_slots = ack_window;
        if (state_r == ST_SEND && limit_r != 8'h00) begin
            timer_start = 1'b1;
        end else if (state_r == ST_WAIT && !ack_seen && timer_expired &&
                     sends_r < limit_r) begin
            timer_start = 1'b1;
            timer_slots = backoff_slots;
        end
    end

    slot_timer #(
        .SLOT_LEN (SLOT_LEN)
    ) u_slot_timer (
        .clock   (clock),
        .rst     (rst),
        .ce      (ce),
        .start   (timer_start),
        .slots   (timer_slots),
        .busy    (timer_busy),
        .expired (timer_expired)
    );

    // Retransmission sequencer. The limit is latched per packet so that a
    // write in mid-flight does not change how often this packet is sent.
    always_ff @(posedge clock) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            limit_r   <= 8'h00;
            sends_r   <= 8'h00;
            tx_start  <= 1'b0;
            tx_done   <= 1'b0;
            tx_failed <= 1'b0;
        end else if (ce) begin
            tx_start  <= 1'b0;
            tx_done   <= 1'b0;
            tx_failed <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    if (tx_request) begin
                        limit_r <= retry_limit_r;
                        sends_r <= 8'h00;
                        state_r <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    tx_start <= 1'b1;
                    sends_r  <= sends_r + 8'h01;
                    if (limit_r == 8'h00) begin
                        tx_done <= 1'b1;
                        state_r <= ST_IDLE;
                    end else begin
                        state_r <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (ack_seen) begin
                        tx_done <= 1'b1;
                        state_r <= ST_IDLE;
                    end else if (timer_expired) begin
                        if (sends_r >= limit_r) begin
                            tx_failed <= 1'b1;
                            state_r   <= ST_IDLE;
                        end else begin
                            state_r <= ST_BACKOFF;
                        end
                    end
                end
                ST_BACKOFF: begin
                    if (timer_expired) begin
                        state_r <= ST_SEND;
                    end
                end
            endcase
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_no_retry_done: assert property (
        tx_start && limit_r == 8'h00 |-> tx_done && state_r == ST_IDLE)
        else $error("Send with retries off did not finish at once.");

    a_ack_ends_wait: assert property (
        ce && state_r == ST_WAIT && ack_seen |=> tx_done && !tx_failed)
        else $error("Acknowledgement did not end the wait.");

    a_resend_after: assert property (
        ce && state_r == ST_BACKOFF && timer_expired |=> state_r == ST_SEND)
        else $error("Backoff expiry did not lead to a resend.");

    a_send_bound: assert property (
        tx_start && limit_r != 8'h00 |-> sends_r <= limit_r)
        else $error("Packet sent more often than the limit.");

    a_fail_at_limit: assert property (
        tx_failed |-> sends_r == limit_r && state_r == ST_IDLE)
        else $error("Failure reported before the limit was reached.");

    a_level_range: assert property (
        last_packet_signal_level_r >= SIGNAL_LEVEL_MIN &&
        last_packet_signal_level_r <= SIGNAL_LEVEL_MAX)
        else $error("Signal level left its range.");

    a_limit_read: assert property (
        ce && cmd_valid && !cmd_write && cmd_code == CODE_RETRY_LIMIT
        |=> cmd_done && cmd_rdata == {8'h00, $past(retry_limit_r)})
        else $error("Retry limit read returned a wrong value.");

    a_line_two_range: assert property (
        input_line_two_config_r <= LINE_TWO_MAX &&
        stop_bit_select_r <= STOP_BITS_MAX)
        else $error("Line two mode or stop bits out of range.");

    a_ro_write_refused: assert property (
        ce && cmd_valid && cmd_write && !strap_pending_r &&
        (cmd_code == CODE_SERIAL_HIGH || cmd_code == CODE_SIGNAL_LEVEL)
        |=> cmd_reject && !cmd_done &&
            $stable(serial_number_upper_word_r))
        else $error("Write to a read-only parameter was not refused.");

    a_serial_read: assert property (
        ce && cmd_valid && !cmd_write && cmd_code == CODE_SERIAL_HIGH
        |=> cmd_rdata == $past(serial_number_upper_word_r))
        else $error("Serial word read returned a wrong value.");

endmodule : radio_link_param_store

// ==== radio_link_param_store_tb_top.sv ====
// Self-checking testbench of the radio link parameter store.
`timescale 1ns/10ps
module radio_link_param_store_tb_top;
    import radio_link_param_pkg::*;

    localparam int    SLOT = 8;
    logic             clock;
    logic             rst;
    logic             ce;
    logic             cmd_valid;
    logic             cmd_write;
    logic [7:0]       cmd_code;
    logic [15:0]      cmd_wdata;
    logic             cmd_done;
    logic             cmd_reject;
    logic [15:0]      cmd_rdata;
    logic             tx_request;
    logic             ack_seen;
    logic             tx_start;
    logic             tx_done;
    logic             tx_failed;
    logic             rx_level_valid;
    logic [7:0]       rx_level;
    logic             retry_enable;
    logic [7:0]       input_line_two_config;
    logic             two_stop_bits;
    logic [7:0]       ack_on;
    int               n_mismatch;
    int               n_checks;
    int               n_start;

    radio_link_param_store #(.SLOT_LEN(SLOT)) uut (
        .clock(clock), .rst(rst), .ce(ce),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .cmd_done(cmd_done), .cmd_reject(cmd_reject),
        .cmd_rdata(cmd_rdata), .tx_request(tx_request),
        .ack_seen(ack_seen), .delay_slot_count(8'h02),
        .tx_start(tx_start), .tx_done(tx_done), .tx_failed(tx_failed),
        .rx_level_valid(rx_level_valid), .rx_level(rx_level),
        .serial_high_strap(16'hBEEF), .retry_enable(retry_enable),
        .input_line_two_config(input_line_two_config),
        .two_stop_bits(two_stop_bits)
    );

    far_radio_model far_end (
        .clock(clock), .rst(rst), .new_packet(tx_request),
        .tx_start(tx_start), .ack_on(ack_on), .ack_seen(ack_seen)
    );

    // Free-running clock of 50 ns period.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    // Send pulses are tallied where they are settled.
    always @(negedge clock) begin
        if (tx_start === 1'b1) n_start <= n_start + 1;
    end

    // Compare one value and report a difference at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    // One command; the answer pulse is looked at in its only cycle.
    // Lines are scrambled after the taking edge so stale values cannot help.
    task automatic do_cmd(input logic w, input logic [7:0] c,
                          input logic [15:0] d, input logic rej,
                          input logic [15:0] rd);
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_code  = c;
        cmd_wdata = d;
        @(negedge clock);
        cmd_valid = 1'b0;
        cmd_code  = ~c;
        cmd_wdata = ~d;
        check(cmd_reject, rej);
        check(cmd_done, !rej);
        if (!w && !rej) check(cmd_rdata, rd);
    endtask : do_cmd

    // Report a received packet level.
    task automatic set_level(input logic [7:0] v);
        @(negedge clock);
        rx_level_valid = 1'b1;
        rx_level       = v;
        @(negedge clock);
        rx_level_valid = 1'b0;
        rx_level       = ~v;
    endtask : set_level

    // One packet with a bounded wait for its outcome.
    task automatic run_tx(input int exp_sends, input logic exp_done);
        logic done_seen;
        logic fail_seen;
        done_seen = 1'b0;
        fail_seen = 1'b0;
        @(negedge clock);
        n_start    = 0;
        tx_request = 1'b1;
        @(negedge clock);
        tx_request = 1'b0;
        for (int i = 0; i < 600; i++) begin
            @(negedge clock);
            done_seen = tx_done;
            fail_seen = tx_failed;
            if (done_seen || fail_seen) break;
        end
        @(negedge clock);
        check(done_seen, exp_done);
        check(fail_seen, !exp_done);
        check(n_start, exp_sends);
    endtask : run_tx

    // Print the counts and the verdict, then stop.
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // Watchdog: the tests need a few hundred cycles at most.
    initial begin
        repeat (20000) @(posedge clock);
        n_mismatch++;
        complete_run();
    end

    // Main sequence.
    initial begin
        {n_mismatch, n_checks, n_start} = '0;
        {cmd_valid, cmd_write, tx_request, rx_level_valid} = '0;
        cmd_code  = 8'h00;
        cmd_wdata = 16'h0000;
        rx_level  = 8'h00;
        ack_on    = 8'h00;
        rst       = 1'b1;
        ce        = 1'b1;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        repeat (2) @(negedge clock);
        do_cmd(1'b0, CODE_RETRY_LIMIT, 16'h0, 1'b0, 16'h0000);
        do_cmd(1'b0, CODE_LINE_TWO, 16'h0, 1'b0, 16'h0000);
        do_cmd(1'b0, CODE_STOP_BITS, 16'h0, 1'b0, 16'h0000);
        do_cmd(1'b0, CODE_SIGNAL_LEVEL, 16'h0, 1'b0, 16'h0006);
        do_cmd(1'b0, CODE_SERIAL_HIGH, 16'h0, 1'b0, 16'hBEEF);
        check(retry_enable, 1'b0);
        check(two_stop_bits, 1'b0);
        // Stop-bit boundary and an out-of-range value that must not stick.
        do_cmd(1'b1, CODE_STOP_BITS, 16'h1, 1'b0, 16'h0);
        do_cmd(1'b1, CODE_STOP_BITS, 16'h2, 1'b1, 16'h0);
        check(two_stop_bits, 1'b1);
        // Clock enable low: a write is ignored and no answer comes.
        @(negedge clock);
        ce        = 1'b0;
        cmd_valid = 1'b1;
        cmd_write = 1'b1;
        cmd_code  = CODE_STOP_BITS;
        cmd_wdata = 16'h0000;
        @(negedge clock);
        cmd_valid = 1'b0;
        check(cmd_done, 1'b0);
        check(cmd_reject, 1'b0);
        check(two_stop_bits, 1'b1);
        ce        = 1'b1;
        // Every line-two mode, then one past the top.
        // host sets mode first.
        for (int m = 2; m >= 0; m--) begin
            do_cmd(1'b1, CODE_LINE_TWO, 16'(m), 1'b0, 16'h0);
            check(input_line_two_config, 8'(m));
        end
        do_cmd(1'b1, CODE_LINE_TWO, 16'h3, 1'b1, 16'h0);
        check(input_line_two_config, LINE_TWO_UNUSED);
        // Read-only places, an unknown code and an over-wide retry value.
        do_cmd(1'b1, CODE_SIGNAL_LEVEL, 16'h20, 1'b1, 16'h0);
        do_cmd(1'b1, CODE_SERIAL_HIGH, 16'h1234, 1'b1, 16'h0);
        do_cmd(1'b0, 8'h99, 16'h0, 1'b1, 16'h0);
        do_cmd(1'b1, CODE_RETRY_LIMIT, 16'h1FF, 1'b1, 16'h0);
        do_cmd(1'b1, CODE_RETRY_LIMIT, 16'hFF, 1'b0, 16'h0);
        do_cmd(1'b0, CODE_RETRY_LIMIT, 16'h0, 1'b0, 16'h00FF);
        do_cmd(1'b0, CODE_SERIAL_HIGH, 16'h0, 1'b0, 16'hBEEF);
        // Levels inside and beyond both ends of the range.
        set_level(8'h20);
        do_cmd(1'b0, CODE_SIGNAL_LEVEL, 16'h0, 1'b0, 16'h0020);
        set_level(8'h02);
        do_cmd(1'b0, CODE_SIGNAL_LEVEL, 16'h0, 1'b0, 16'h0006);
        set_level(8'h50);
        do_cmd(1'b0, CODE_SIGNAL_LEVEL, 16'h0, 1'b0, 16'h0036);
        // Retries off: a single send finishes without acknowledgement.
        do_cmd(1'b1, CODE_RETRY_LIMIT, 16'h0, 1'b0, 16'h0);
        check(retry_enable, 1'b0);
        run_tx(1, 1'b1);
        // Three sends allowed and a silent peer: give up after three.
        do_cmd(1'b1, CODE_RETRY_LIMIT, 16'h3, 1'b0, 16'h0);
        check(retry_enable, 1'b1);
        run_tx(3, 1'b0);
        // Peer answers the second send, then the first: resending stops there.
        ack_on = 8'h02;
        run_tx(2, 1'b1);
        ack_on = 8'h01;
        run_tx(1, 1'b1);
        complete_run();
    end
endmodule : radio_link_param_store_tb_top

// ==== slot_timer.sv ====
// Counts a given number of delay slots and pulses when they have passed.
`timescale 1ns/10ps
module slot_timer
    import radio_link_param_pkg::*;
#(
    parameter int SLOT_LEN = SLOT_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic [7:0] slots,
    output logic            busy,
    output logic            expired
);
    localparam int CW = $clog2(SLOT_LEN + 1);
    localparam logic [CW-1:0] LAST = CW'(SLOT_LEN - 1);

    logic [CW-1:0] cyc_r;
    logic [7:0]    left_r;

    // A zero-slot request expires on the edge after it starts.
    always_ff @(posedge clock) begin
        if (rst) begin
            busy    <= 1'b0;
            expired <= 1'b0;
            cyc_r   <= '0;
            left_r  <= 8'h00;
        end else if (ce) begin
            expired <= 1'b0;
            if (start) begin
                busy   <= 1'b1;
                left_r <= slots;
                cyc_r  <= '0;
            end else if (busy) begin
                if (left_r == 8'h00) begin
                    busy    <= 1'b0;
                    expired <= 1'b1;
                end else if (cyc_r == LAST) begin
                    cyc_r  <= '0;
                    left_r <= left_r - 8'h01;
                end else begin
                    cyc_r <= cyc_r + CW'(1);
                end
            end
        end
    end
endmodule : slot_timer
